// ===== rtl/cwcb_defines.svh
/*
 * constants of the instruction executer: bus offsets, field positions,
 * opcode patterns, arithmetic limits, reset values and phase numbers.
 * assumes it is included by bare name from rtl/.
 */
`ifndef CWCB_DEFINES_SVH
`define CWCB_DEFINES_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define CWCB_ADR_CMD   8'h00
`define CWCB_ADR_WORKING_REGISTER  8'h04
`define CWCB_ADR_STAT  8'h08
`define CWCB_ADR_STATE 8'h0c

// ----------------------------------------------------------------------
// status field positions, status and working register reset values
// ----------------------------------------------------------------------
`define CWCB_ST_C      0
`define CWCB_ST_DC     1
`define CWCB_ST_Z      2
`define CWCB_ST_PD_N   3
`define CWCB_ST_TO_N   4
`define CWCB_ST_RST    5'h18
`define CWCB_WORKING_REGISTER_RST  8'h00

// ----------------------------------------------------------------------
// state register field positions
// ----------------------------------------------------------------------
`define CWCB_SR_STATE  1:0
`define CWCB_SR_PHASE  3:2
`define CWCB_SR_SKIP   4
`define CWCB_SR_ILL    5

// ----------------------------------------------------------------------
// opcode patterns
// ----------------------------------------------------------------------
`define CWCB_OP_CLEAR_WATCHDOG_INSTR 16'h0004
`define CWCB_OP_COMPLEMENT_REG_INSTR   7'h09
`define CWCB_OP_DAW    7'h17
`define CWCB_OP_CPLT   8'h30
`define CWCB_OP_CPEQ   8'h31
`define CWCB_OP_CPGT   8'h32
`define CWCB_DEST_BIT  8

// ----------------------------------------------------------------------
// decimal adjust limits and instruction phases
// ----------------------------------------------------------------------
`define CWCB_BCD_MAX   4'h9
`define CWCB_BCD_ADJ   5'h06
`define CWCB_Q1        2'h0
`define CWCB_Q2        2'h1
`define CWCB_Q3        2'h2
`define CWCB_Q4        2'h3

`endif

// ===== rtl/cwcb_pkg.sv
/*
 * types of the instruction executer: states, operation classes,
 * status flags and the result bundle of the data path.
 * assumes cwcb_defines.svh is on the include path.
 */
`default_nettype none
`include "cwcb_defines.svh"

package cwcb_pkg;

	typedef enum logic [1:0] {
		CWCB_IDLE = 2'b00,
		CWCB_EXEC = 2'b01,
		CWCB_SKIP = 2'b10
	} cwcb_state_t;

	typedef enum logic [2:0] {
		CWCB_NOP    = 3'b000,
		CWCB_CLEAR_WATCHDOG_INSTR = 3'b001,
		CWCB_COMPLEMENT_REG_INSTR   = 3'b010,
		CWCB_CPEQ   = 3'b011,
		CWCB_CPGT   = 3'b100,
		CWCB_CPLT   = 3'b101,
		CWCB_DAW    = 3'b110
	} cwcb_op_t;

	typedef struct packed {
		logic to_n;
		logic pd_n;
		logic z;
		logic dc;
		logic c;
	} cwcb_flags_t;

	typedef struct packed {
		logic [7:0]  res;
		logic        wr_f;
		logic        wr_w;
		logic        skip;
		cwcb_flags_t flags;
	} cwcb_alu_o_t;

	function automatic cwcb_op_t cwcb_decode(input logic [15:0] i);
		cwcb_op_t o;
		o = CWCB_NOP;
		if (i == `CWCB_OP_CLEAR_WATCHDOG_INSTR) o = CWCB_CLEAR_WATCHDOG_INSTR;
		else if (i[15:9] == `CWCB_OP_COMPLEMENT_REG_INSTR) o = CWCB_COMPLEMENT_REG_INSTR;
		else if (i[15:9] == `CWCB_OP_DAW) o = CWCB_DAW;
		else if (i[15:8] == `CWCB_OP_CPEQ) o = CWCB_CPEQ;
		else if (i[15:8] == `CWCB_OP_CPGT) o = CWCB_CPGT;
		else if (i[15:8] == `CWCB_OP_CPLT) o = CWCB_CPLT;
		return o;
	endfunction : cwcb_decode

endpackage : cwcb_pkg

`default_nettype wire

// ===== rtl/cwcb_alu.sv
/*
 * data path of the executer: complement, unsigned compare, decimal
 * adjust and watchdog clear flag effects, purely combinational.
 * assumes operands are stable for the process phase.
 */
`default_nettype none
`include "cwcb_defines.svh"

module cwcb_alu (
	// operation
	input  wire cwcb_pkg::cwcb_op_t    op,
	input  wire logic                  dest,
	// operands
	input  wire logic [7:0]            fdat,
	input  wire logic [7:0]            working_register,
	input  wire cwcb_pkg::cwcb_flags_t fin,
	// result
	output var  cwcb_pkg::cwcb_alu_o_t o
);

	wire logic [8:0] diff = {1'b0, fdat} - {1'b0, working_register};
	wire logic       eq   = (diff == 9'h000);
	wire logic       lt   = diff[8];
	wire logic       lo_a = (working_register[3:0] > `CWCB_BCD_MAX) | fin.dc;
	wire logic       hi_a = (working_register[7:4] > `CWCB_BCD_MAX) | fin.c;
	wire logic [4:0] lo_s = {1'b0, working_register[3:0]} + (lo_a ? `CWCB_BCD_ADJ : 5'h00);
	wire logic [4:0] hi_s = {1'b0, working_register[7:4]} + (hi_a ? `CWCB_BCD_ADJ : 5'h00);

	always_comb begin
		o       = '0;
		o.flags = fin;
		case (op)
			cwcb_pkg::CWCB_CLEAR_WATCHDOG_INSTR: begin
				o.flags.to_n = 1'b1;
				o.flags.pd_n = 1'b1;
			end
			cwcb_pkg::CWCB_COMPLEMENT_REG_INSTR: begin
				o.res     = ~fdat;
				o.wr_f    = dest;
				o.wr_w    = ~dest;
				o.flags.z = (~fdat == 8'h00);
			end
			// compares only steer the skip; no write, no flag
			cwcb_pkg::CWCB_CPEQ: o.skip = eq;
			cwcb_pkg::CWCB_CPGT: o.skip = ~eq & ~lt;
			cwcb_pkg::CWCB_CPLT: o.skip = lt;
			cwcb_pkg::CWCB_DAW: begin
				o.res     = {hi_s[3:0], lo_s[3:0]};
				o.wr_f    = 1'b1;
				o.wr_w    = ~dest;
				o.flags.c = fin.c | (hi_a & hi_s[4]);
			end
			default: o.skip = 1'b0;
		endcase
	end

endmodule : cwcb_alu

`default_nettype wire

// ===== rtl/cwcb_exec.sv
/*
 * instruction executer with watchdog clear, complement, compare-skip
 * and decimal adjust, reached as a classic wishbone slave.
 * assumes the core register file answers FILE_RDATA combinationally
 * from FILE_ADDR on the same clock, and the watchdog and fetch logic
 * take one-cycle pulses on the same clock.
 */
//
// Function
// - clearing the watchdog instruction (0004) zeroes the watchdog count within one instruction cycle.
// - the same instruction also zeroes the watchdog postscaler.
// - it sets the expiry and sleep status flags to one and changes no other flag.
// - complement inverts the register, writes to working register (d=0) or register (d=1), and updates only zero.
// - compare-equal skips the prefetched instruction as a nop when register equals working register.
// - compare-greater skips when the register exceeds the working register.
// - compare-less skips when the register is below the working register.
// - all compares use unsigned subtraction, change no flag and write nothing.
// - decimal adjust adds six to the low nibble when above nine or half carry is set.
// - decimal adjust adds six to the high nibble when above nine or carry is set.
// - decimal adjust always writes the register and also the working register when s is zero.
// - decimal adjust yields packed bcd in one cycle and changes only carry.
`default_nettype none
`include "cwcb_defines.svh"

module cwcb_exec (
	// clock and reset
	input  wire logic        CLK,
	input  wire logic        NRST,
	// wishbone slave
	input  wire logic [7:0]  ADR_I,
	input  wire logic [31:0] DAT_I,
	output logic      [31:0] DAT_O,
	input  wire logic        WE_I,
	input  wire logic [3:0]  SEL_I,
	input  wire logic        STB_I,
	input  wire logic        CYC_I,
	output logic             ACK_O,
	// register file
	output logic      [7:0]  FILE_ADDR,
	output logic      [7:0]  FILE_WDATA,
	output logic             FILE_WE,
	input  wire logic [7:0]  FILE_RDATA,
	// watchdog
	output logic             WDT_CLR,
	output logic             POST_CLR,
	// fetch pipeline
	output logic             FLUSH
);

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	cwcb_pkg::cwcb_state_t state_r, state_nxt;
	cwcb_pkg::cwcb_op_t    op_r;
	cwcb_pkg::cwcb_flags_t status_r, status_nxt;
	cwcb_pkg::cwcb_alu_o_t alu, alu_r;
	logic [1:0]  q_r, q_nxt;
	logic [15:0] instr_r;
	logic [7:0]  fdata_r;
	logic [7:0]  working_register_r, working_register_nxt;
	logic [7:0]  faddr_r;
	logic [7:0]  fwdata_r;
	logic        fwe_r;
	logic        wdt_r;
	logic        flush_r;
	logic        skip_r;
	logic        ill_r;
	logic        ack_r;
	logic [31:0] dat_r;
	logic [31:0] rd_data;

	// ------------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------------
	wire logic req      = CYC_I & STB_I & ~ack_r;
	wire logic wr       = req & WE_I;
	wire logic hit_cmd  = (ADR_I == `CWCB_ADR_CMD);
	wire logic hit_working_register = (ADR_I == `CWCB_ADR_WORKING_REGISTER);
	wire logic hit_stat = (ADR_I == `CWCB_ADR_STAT);
	wire logic hit_st   = (ADR_I == `CWCB_ADR_STATE);
	wire logic idle     = (state_r == cwcb_pkg::CWCB_IDLE);
	wire logic start    = wr & hit_cmd & (&SEL_I[1:0]) & idle;
	wire logic sw_working_register  = wr & hit_working_register & SEL_I[0] & idle;
	wire logic sw_stat  = wr & hit_stat & SEL_I[0] & idle;
	wire cwcb_pkg::cwcb_op_t dec_op = cwcb_pkg::cwcb_decode(DAT_I[15:0]);
	wire logic is_op    = (dec_op != cwcb_pkg::CWCB_NOP);
	wire logic exec     = (state_r == cwcb_pkg::CWCB_EXEC);
	wire logic at_q2    = exec & (q_r == `CWCB_Q2);
	wire logic at_q3    = exec & (q_r == `CWCB_Q3);
	wire logic at_q4    = exec & (q_r == `CWCB_Q4);
	wire logic last_q   = (q_r == `CWCB_Q4);
	wire logic [7:0] state_rd = {2'b00, ill_r, skip_r, q_r, state_r};

	// unmapped offsets read as zero
	always_comb begin
		rd_data = 32'h0000_0000;
		if (hit_cmd) begin
			rd_data = {16'h0000, instr_r};
		end else if (hit_working_register) begin
			rd_data = {24'h000000, working_register_r};
		end else if (hit_stat) begin
			rd_data = {27'h0000000, status_r};
		end else if (hit_st) begin
			rd_data = {24'h000000, state_rd};
		end
	end

	// ------------------------------------------------------------------
	// data path
	// ------------------------------------------------------------------
	cwcb_alu u_alu (
		.op   (op_r),
		.dest (instr_r[`CWCB_DEST_BIT]),
		.fdat (fdata_r),
		.working_register (working_register_r),
		.fin  (status_r),
		.o    (alu)
	);

	// ------------------------------------------------------------------
	// sequencer: q1 decode, q2 read, q3 process, q4 write
	// ------------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		q_nxt     = q_r;
		case (state_r)
			cwcb_pkg::CWCB_IDLE: begin
				if (start) begin
					state_nxt = cwcb_pkg::CWCB_EXEC;
					q_nxt     = `CWCB_Q1;
				end
			end
			cwcb_pkg::CWCB_EXEC: begin
				q_nxt = q_r + 2'h1;
				if (last_q) begin
					// a taken skip runs one nop cycle
					state_nxt = alu_r.skip ? cwcb_pkg::CWCB_SKIP
					                       : cwcb_pkg::CWCB_IDLE;
				end
			end
			cwcb_pkg::CWCB_SKIP: begin
				q_nxt = q_r + 2'h1;
				if (last_q) begin
					state_nxt = cwcb_pkg::CWCB_IDLE;
				end
			end
			default: begin
				state_nxt = cwcb_pkg::CWCB_IDLE;
				q_nxt     = `CWCB_Q1;
			end
		endcase
	end

	// instruction results win over software writes
	always_comb begin
		working_register_nxt   = working_register_r;
		status_nxt = status_r;
		if (at_q4) begin
			status_nxt = alu_r.flags;
			if (alu_r.wr_w) begin
				working_register_nxt = alu_r.res;
			end
		end else begin
			if (sw_working_register) begin
				working_register_nxt = DAT_I[7:0];
			end
			if (sw_stat) begin
				status_nxt = DAT_I[4:0];
			end
		end
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			state_r  <= cwcb_pkg::CWCB_IDLE;
			q_r      <= `CWCB_Q1;
			op_r     <= cwcb_pkg::CWCB_NOP;
			instr_r  <= 16'h0000;
			faddr_r  <= 8'h00;
			fdata_r  <= 8'h00;
			working_register_r   <= `CWCB_WORKING_REGISTER_RST;
			status_r <= `CWCB_ST_RST;
			alu_r    <= '0;
			skip_r   <= 1'b0;
			ill_r    <= 1'b0;
		end else begin
			state_r  <= state_nxt;
			q_r      <= q_nxt;
			working_register_r   <= working_register_nxt;
			status_r <= status_nxt;
			if (start) begin
				instr_r <= DAT_I[15:0];
				op_r    <= dec_op;
				faddr_r <= DAT_I[7:0];
				ill_r   <= ~is_op;
			end
			if (at_q2) begin
				fdata_r <= FILE_RDATA;
			end
			if (at_q3) begin
				alu_r  <= alu;
				skip_r <= alu.skip;
			end
		end
	end

	// ------------------------------------------------------------------
	// output pulses, raised for the q4 cycle
	// ------------------------------------------------------------------
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			fwe_r    <= 1'b0;
			fwdata_r <= 8'h00;
			wdt_r    <= 1'b0;
			flush_r  <= 1'b0;
		end else begin
			fwe_r    <= at_q3 & alu.wr_f;
			fwdata_r <= at_q3 ? alu.res : fwdata_r;
			wdt_r    <= at_q3 & (op_r == cwcb_pkg::CWCB_CLEAR_WATCHDOG_INSTR);
			flush_r  <= at_q3 & alu.skip;
		end
	end

	// ------------------------------------------------------------------
	// wishbone answer: ack one cycle after the request
	// ------------------------------------------------------------------
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			ack_r <= 1'b0;
			dat_r <= 32'h0000_0000;
		end else begin
			ack_r <= req;
			dat_r <= req ? rd_data : dat_r;
		end
	end

	assign DAT_O      = dat_r;
	assign ACK_O      = ack_r;
	assign FILE_ADDR  = faddr_r;
	assign FILE_WDATA = fwdata_r;
	assign FILE_WE    = fwe_r;
	assign WDT_CLR    = wdt_r;
	assign POST_CLR   = wdt_r;
	assign FLUSH      = flush_r;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!NRST);

	wire logic is_cmp = (op_r == cwcb_pkg::CWCB_CPEQ) |
	                    (op_r == cwcb_pkg::CWCB_CPGT) |
	                    (op_r == cwcb_pkg::CWCB_CPLT);
	wire logic is_daw = (op_r == cwcb_pkg::CWCB_DAW);

	a_wdt_clear_time: assert property (
		(start && dec_op == cwcb_pkg::CWCB_CLEAR_WATCHDOG_INSTR)
		|-> ##4 WDT_CLR ##1 !WDT_CLR)
		else $error("watchdog clear not in q4");

	a_post_clear_pair: assert property (
		WDT_CLR == POST_CLR)
		else $error("postscaler clear not with watchdog");

	a_clear_watchdog_instr_flags_set: assert property (
		WDT_CLR |=> status_r.to_n && status_r.pd_n &&
		status_r.z == $past(status_r.z) &&
		status_r.c == $past(status_r.c) &&
		status_r.dc == $past(status_r.dc))
		else $error("clear watchdog flags wrong");

	a_complement_reg_instr_result: assert property (
		(at_q4 && op_r == cwcb_pkg::CWCB_COMPLEMENT_REG_INSTR)
		|-> alu_r.res == ~fdata_r &&
		FILE_WE == instr_r[`CWCB_DEST_BIT]
		##1 status_r.z == ($past(fdata_r) == 8'hff))
		else $error("complement result wrong");

	a_cpeq_skip: assert property (
		(at_q4 && op_r == cwcb_pkg::CWCB_CPEQ)
		|-> FLUSH == (fdata_r == working_register_r))
		else $error("equal skip wrong");

	a_cpgt_skip: assert property (
		(at_q4 && op_r == cwcb_pkg::CWCB_CPGT)
		|-> FLUSH == (fdata_r > working_register_r))
		else $error("greater skip wrong");

	a_cplt_skip: assert property (
		(at_q4 && op_r == cwcb_pkg::CWCB_CPLT)
		|-> FLUSH == (fdata_r < working_register_r))
		else $error("less skip wrong");

	a_cmp_no_effect: assert property (
		(at_q4 && is_cmp) |-> !FILE_WE
		##1 status_r == $past(status_r) && working_register_r == $past(working_register_r))
		else $error("compare changed state");

	a_daw_low_nib: assert property (
		(at_q4 && is_daw) |-> FILE_WDATA[3:0] ==
		((working_register_r[3:0] > `CWCB_BCD_MAX || status_r.dc) ?
		 working_register_r[3:0] + 4'h6 : working_register_r[3:0]))
		else $error("adjust low nibble wrong");

	a_daw_high_nib: assert property (
		(at_q4 && is_daw) |-> FILE_WDATA[7:4] ==
		((working_register_r[7:4] > `CWCB_BCD_MAX || status_r.c) ?
		 working_register_r[7:4] + 4'h6 : working_register_r[7:4]))
		else $error("adjust high nibble wrong");

	a_daw_dest_write: assert property (
		(at_q4 && is_daw) |-> FILE_WE
		##1 working_register_r == ($past(instr_r[`CWCB_DEST_BIT]) ?
		$past(working_register_r) : $past(FILE_WDATA)))
		else $error("adjust destination wrong");

	a_daw_only_carry: assert property (
		(at_q4 && is_daw) |-> !FLUSH
		##1 status_r.z == $past(status_r.z) &&
		status_r.dc == $past(status_r.dc) &&
		status_r.to_n == $past(status_r.to_n) && idle)
		else $error("adjust changed other flags");

	a_skip_nop_cycle: assert property (
		FLUSH |=> (state_r == cwcb_pkg::CWCB_SKIP) [*4]
		##1 idle)
		else $error("skip cycle length wrong");

	c_clear_watchdog_instr: cover property (WDT_CLR);
	c_skip: cover property (FLUSH ##5 idle);
	c_daw_carry: cover property (
		at_q4 && is_daw ##1 status_r.c);
	c_complement_reg_instr_w: cover property (
		at_q4 && op_r == cwcb_pkg::CWCB_COMPLEMENT_REG_INSTR && !FILE_WE);

endmodule : cwcb_exec

`default_nettype wire

// ===== verification/cwcb_file_model.sv
/*
 * partner model: the core register file seen by the executer.
 * assumes reads are combinational from the address on the same clock
 * and a write lands at the rising edge where the write strobe is high.
 */
`default_nettype none

module cwcb_file_model (
	// clock
	input  wire logic       CLK,
	// register file port
	input  wire logic [7:0] FILE_ADDR,
	input  wire logic [7:0] FILE_WDATA,
	input  wire logic       FILE_WE,
	output logic      [7:0] FILE_RDATA
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] mem [256];

	// filled with a pattern so that no location reads unknown
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'(i) ^ 8'h5a;
		end
	end

	assign FILE_RDATA = mem[FILE_ADDR];

	always @(posedge CLK) begin
		if (FILE_WE) begin
			mem[FILE_ADDR] <= FILE_WDATA;
		end
	end

endmodule : cwcb_file_model

`default_nettype wire

// ===== verification/cwcb_exec_bench.sv
/*
 * self-checking bench of the executer: wishbone master tasks, pulse
 * monitor and one task per scenario.
 * assumes cwcb_defines.svh is on the include path.
 */
`default_nettype none
`include "cwcb_defines.svh"

module cwcb_exec_bench;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk, nrst, we, stb, cyc, ack, fwe, wclr, pclr, flush;
	logic [7:0]  adr, faddr, fwdata, frdata, w_addr, w_data;
	logic [3:0]  sel;
	logic [31:0] dat_w, dat_r, rd;
	int          err_total, cmp_count, cyc_n, n_we, n_wdt, n_post, n_fl;

	cwcb_exec dut_u (.CLK(clk), .NRST(nrst), .ADR_I(adr), .DAT_I(dat_w),
		.DAT_O(dat_r), .WE_I(we), .SEL_I(sel), .STB_I(stb), .CYC_I(cyc),
		.ACK_O(ack), .FILE_ADDR(faddr), .FILE_WDATA(fwdata),
		.FILE_WE(fwe), .FILE_RDATA(frdata), .WDT_CLR(wclr),
		.POST_CLR(pclr), .FLUSH(flush));

	cwcb_file_model fm_u (.CLK(clk), .FILE_ADDR(faddr),
		.FILE_WDATA(fwdata), .FILE_WE(fwe), .FILE_RDATA(frdata));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// ------------------------------------------------------------------
	// pulse monitor and hang guard
	// ------------------------------------------------------------------
	always @(posedge clk) begin
		cyc_n++;
		if (fwe === 1'b1) begin
			n_we++;
			w_addr = faddr;
			w_data = fwdata;
		end
		if (wclr === 1'b1) n_wdt++;
		if (pclr === 1'b1) n_post++;
		if (flush === 1'b1) n_fl++;
		if (cyc_n == 20000) begin
			err_total++;
			conclude();
		end
	end

	// ------------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------------
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : conclude

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// one classic cycle; request held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat_w <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) err_total++;
		rd = dat_r;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : wb

	task automatic rchk(input string nm, input logic [7:0] a,
		input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(nm, rd, e);
	endtask : rchk

	// start an instruction and poll until the executer is idle again
	task automatic run(input logic [15:0] op);
		int n;
		n_we = 0;
		n_wdt = 0;
		n_post = 0;
		n_fl = 0;
		n = 0;
		wb(1'b1, `CWCB_ADR_CMD, {16'h0, op});
		do begin
			wb(1'b0, `CWCB_ADR_STATE, 32'h0);
			n++;
		end while (rd[1:0] !== 2'b00 && n < 20);
		if (n >= 20) err_total++;
	endtask : run

	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task automatic t_reset;
		rchk("working_register reset", `CWCB_ADR_WORKING_REGISTER, 32'h0);
		rchk("status reset", `CWCB_ADR_STAT, 32'h18);
		rchk("state reset", `CWCB_ADR_STATE, 32'h0);
		// a command written with only one byte lane must not start
		sel <= 4'h1;
		wb(1'b1, `CWCB_ADR_CMD, 32'h0004);
		sel <= 4'hf;
		rchk("narrow cmd ignored", `CWCB_ADR_STATE, 32'h0);
		wb(1'b1, 8'h10, 32'hffffffff);
		rchk("unmapped", 8'h10, 32'h0);
	endtask : t_reset

	task automatic t_clear_watchdog_instr;
		wb(1'b1, `CWCB_ADR_STAT, 32'h07);
		run(16'h0005);
		chk("near opcode clear", n_wdt, 0);
		chk("unsupported flag", rd[5], 1);
		run(16'h0004);
		chk("watchdog clear", n_wdt, 1);
		chk("supported flag", rd[5], 0);
		chk("postscaler clear", n_post, 1);
		rchk("status after clear", `CWCB_ADR_STAT, 32'h1f);
		chk("clear file write", n_we, 0);
	endtask : t_clear_watchdog_instr

	task automatic t_complement_reg_instr;
		fm_u.mem[8'h21] = 8'h13;
		fm_u.mem[8'h22] = 8'hff;
		wb(1'b1, `CWCB_ADR_STAT, 32'h1f);
		run(16'h1221);
		rchk("complement_reg_instr working_register", `CWCB_ADR_WORKING_REGISTER, 32'hec);
		rchk("complement_reg_instr z clear", `CWCB_ADR_STAT, 32'h1b);
		chk("complement_reg_instr w no write", n_we, 0);
		run(16'h1322);
		chk("complement_reg_instr f write", n_we, 1);
		chk("complement_reg_instr f addr", w_addr, 32'h22);
		chk("complement_reg_instr f data", w_data, 32'h00);
		rchk("complement_reg_instr f working_register kept", `CWCB_ADR_WORKING_REGISTER, 32'hec);
		rchk("complement_reg_instr z set", `CWCB_ADR_STAT, 32'h1f);
	endtask : t_complement_reg_instr

	task automatic t_cmp;
		logic [7:0] fv [4];
		logic [7:0] wv [4];
		logic       sk;
		fv = '{8'h05, 8'h06, 8'h04, 8'hff};
		wv = '{8'h05, 8'h05, 8'h05, 8'h01};
		for (int o = 0; o < 3; o++) begin
			for (int i = 0; i < 4; i++) begin
				fm_u.mem[8'h40] = fv[i];
				wb(1'b1, `CWCB_ADR_WORKING_REGISTER, {24'h0, wv[i]});
				wb(1'b1, `CWCB_ADR_STAT, 32'h0d);
				run({8'h30 + 8'(o), 8'h40});
				sk = (o == 0) ? fv[i] < wv[i] :
					(o == 1) ? fv[i] == wv[i] : fv[i] > wv[i];
				chk("skip flush", n_fl, 32'(sk));
				chk("skip state", rd[4], 32'(sk));
				chk("compare write", n_we, 0);
				rchk("compare flags", `CWCB_ADR_STAT, 32'h0d);
				rchk("compare working_register", `CWCB_ADR_WORKING_REGISTER, 32'(wv[i]));
			end
		end
	endtask : t_cmp

	task automatic t_daw;
		logic [7:0] wv [6];
		logic [1:0] fl [6];
		logic [3:0] lo;
		logic [4:0] hi;
		logic [7:0] res;
		logic       s;
		wv = '{8'ha5, 8'hce, 8'h38, 8'h12, 8'h99, 8'h9a};
		fl = '{2'b00, 2'b00, 2'b01, 2'b10, 2'b00, 2'b00};
		for (int i = 0; i < 6; i++) begin
			lo = wv[i][3:0];
			if (lo > 4'h9 || fl[i][0]) lo = lo + 4'h6;
			hi = {1'b0, wv[i][7:4]};
			if (hi > 5'h09 || fl[i][1]) hi = hi + 5'h06;
			res = {hi[3:0], lo};
			s = 1'(i);
			wb(1'b1, `CWCB_ADR_WORKING_REGISTER, {24'h0, wv[i]});
			wb(1'b1, `CWCB_ADR_STAT, {29'h3, 1'b1, fl[i][0], fl[i][1]});
			run({7'h17, s, 8'h50});
			chk("daw writes", n_we, 1);
			chk("daw addr", w_addr, 32'h50);
			chk("daw result", w_data, 32'(res));
			rchk("daw working_register", `CWCB_ADR_WORKING_REGISTER, s ? wv[i] : res);
			rchk("daw flags", `CWCB_ADR_STAT,
				{29'h3, 1'b1, fl[i][0], fl[i][1] | hi[4]});
		end
	endtask : t_daw

	initial begin
		nrst = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h0;
		dat_w = 32'h0;
		sel = 4'hf;
		err_total = 0;
		cmp_count = 0;
		cyc_n = 0;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		t_clear_watchdog_instr();
		t_complement_reg_instr();
		t_cmp();
		t_daw();
		conclude();
	end

endmodule : cwcb_exec_bench

`default_nettype wire
